// >>> hsd_pkg.sv
// Summary of operation
// - In HS, SE0 idle over 3 ms reverts to FS before 3.125 ms.
// - Line level sampled 100 us to 875 us after reversion; J means suspend.
// - SE0 at that sample means bus reset; start the speed handshake.
// - Fully suspended within 10 ms of the last bus activity.
// - Resume signalling no earlier than 5 ms after last activity.
// - SE0 while suspended starts the handshake after a 4 ms wake wait.
// - In FS, SE0 longer than 2.5 us starts the handshake.
// - Host holds reset at least 10 ms; controller waits for its end.
// - From suspend, a 1.65 ms chirp K completes within 6 ms of wake.
// - Chirp uses raw mode, HS transceiver and all-zero transmit data.
// - Chirp K starts no later than 6.0 ms after last activity.
// - Chirp K lasts at least 1.0 ms, ends before 7.0 ms.
// - Chirp K is timed by a count of 66000 cycles.
// - Line level is watched for host chirps once the chirp ends.
// - An HS host chirps within 100 us of our chirp end.
// - No host chirp 1.0 to 2.5 ms after chirp: back to FS.
// - Handshake entry may come up to 4 ms after last activity.
`default_nettype none
package hsd_pkg;
  // ----------------------------------------------------------------
  // Clock and time conversion
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 40;
  function automatic int unsigned min_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction : min_cyc
  function automatic int unsigned max_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ) / 1000;
    return (c == 0) ? 1 : c;
  endfunction : max_cyc
  localparam int unsigned T_REVERT_NS = 3_050_000;
  localparam int unsigned T_SAMPLE_MIN_NS = 100_000;
  localparam int unsigned T_SAMPLE_NS = 200_000;
  localparam int unsigned T_SAMPLE_MAX_NS = 875_000;
  localparam int unsigned T_LISTEN_NS = 1_500_000;
  localparam int unsigned T_RESUME_MIN_NS = 5_000_000;
  localparam int unsigned T_RESUME_K_NS = 2_000_000;
  localparam int unsigned T_WAKE_NS = 4_000_000;
  localparam int unsigned T_SE0_FILT_NS = 2_500;
  localparam int unsigned T_CHIRP_FILT_NS = 2_500;
  localparam int unsigned REVERT_CYC_DEF = min_cyc(T_REVERT_NS);
  localparam int unsigned SAMPLE_CYC_DEF = min_cyc(T_SAMPLE_NS);
  localparam int unsigned SAMPLE_MAX_CYC_DEF = max_cyc(T_SAMPLE_MAX_NS);
  localparam int unsigned LISTEN_CYC_DEF = min_cyc(T_LISTEN_NS);
  localparam int unsigned RESUME_MIN_CYC_DEF = min_cyc(T_RESUME_MIN_NS);
  localparam int unsigned RESUME_K_CYC_DEF = min_cyc(T_RESUME_K_NS);
  localparam int unsigned WAKE_CYC_DEF = max_cyc(T_WAKE_NS);
  localparam int unsigned CHIRP_CYC_DEF = 66000;
  // "More than 2.5 us" needs one cycle beyond the rounded figure
  localparam int unsigned SE0_FILT_CYC = min_cyc(T_SE0_FILT_NS) + 1;
  localparam int unsigned CHIRP_FILT_CYC = min_cyc(T_CHIRP_FILT_NS) + 1;
  localparam int unsigned SETUP_CYC = 5;
  localparam int unsigned CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  // ----------------------------------------------------------------
  // Transceiver encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  localparam logic [1:0] OPSEL_NORMAL = 2'h0;
  localparam logic [1:0] OPSEL_RAW = 2'h2;
  localparam logic SPEED_FS = 1'b1;
  localparam logic SPEED_HS = 1'b0;
  localparam logic [7:0] CHIRP_DATA = 8'h00;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_EVENT = 4'h8;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_HS_BIT = 1;
  localparam int unsigned CTRL_RESUME_BIT = 2;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_RESET = 0;
  localparam int unsigned EV_SUSPEND = 1;
  localparam int unsigned EV_CHIRP_TO = 2;
  localparam int unsigned EV_HOST_CHIRP = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_OFF, ST_FS, ST_HS, ST_REVERT, ST_SUSPEND, ST_RESUME,
    ST_WAKE, ST_SETUP, ST_CHIRP, ST_LISTEN, ST_AWAIT_END
  } hsd_state_t;
endpackage : hsd_pkg
`default_nettype wire

// >>> hsd_axil_regs.sv
`timescale 1ns/1ps
`default_nettype none
module hsd_axil_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic [hsd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hsd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ctrl_enable,
  output logic ctrl_start_hs,
  output logic resume_pulse,
  input wire logic [7:0] status,
  input wire logic [hsd_pkg::EV_W-1:0] event_set
);
  import hsd_pkg::*;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_EVENT);
  endfunction : mapped

  logic wr_fire;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] ev_r;
  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                   s_axi_wready;
  assign ev_clr = (wr_fire && s_axi_awaddr == REG_EVENT && s_axi_wstrb[0])
                  ? s_axi_wdata[EV_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Write channel: both ready together once address and data wait
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_enable <= 1'b0;
      ctrl_start_hs <= 1'b0;
      resume_pulse <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid;
      resume_pulse <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]) begin
          ctrl_enable <= s_axi_wdata[CTRL_EN_BIT];
          ctrl_start_hs <= s_axi_wdata[CTRL_HS_BIT];
          resume_pulse <= s_axi_wdata[CTRL_RESUME_BIT];
        end
      end
    end
  end

  // Sticky events: a set in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (srst) begin
      ev_r <= '0;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | event_set;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        unique case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {30'h00000000, ctrl_start_hs, ctrl_enable};
          REG_STATUS: s_axi_rdata <= {24'h000000, status};
          REG_EVENT: s_axi_rdata <= {28'h0000000, ev_r};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : hsd_axil_regs
`default_nettype wire

// >>> hsd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module hsd_ctrl #(
  parameter int unsigned REVERT_CYC = hsd_pkg::REVERT_CYC_DEF,
  parameter int unsigned SAMPLE_CYC = hsd_pkg::SAMPLE_CYC_DEF,
  parameter int unsigned SAMPLE_MAX_CYC = hsd_pkg::SAMPLE_MAX_CYC_DEF,
  parameter int unsigned CHIRP_CYC = hsd_pkg::CHIRP_CYC_DEF,
  parameter int unsigned LISTEN_CYC = hsd_pkg::LISTEN_CYC_DEF,
  parameter int unsigned RESUME_MIN_CYC = hsd_pkg::RESUME_MIN_CYC_DEF,
  parameter int unsigned RESUME_K_CYC = hsd_pkg::RESUME_K_CYC_DEF,
  parameter int unsigned WAKE_CYC = hsd_pkg::WAKE_CYC_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [hsd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hsd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] line_state,
  output logic transceiver_speed_select,
  output logic termination_speed_select,
  output logic [1:0] operating_mode_select,
  output logic low_power_request_n,
  output logic [7:0] tx_data,
  output logic tx_valid
);
  import hsd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hsd_state_t state_r;
  hsd_state_t state_nxt;
  logic [CNT_W-1:0] st_cnt_r;
  logic [CNT_W-1:0] act_cnt_r;
  logic [1:0] ls_prev_r;
  logic [EV_W-1:0] ev_set_r;
  logic ctrl_enable;
  logic ctrl_start_hs;
  logic resume_pulse;
  logic resume_req_r;
  logic [7:0] status;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v == CNT_MAX) ? v : v + CNT_ONE;
  endfunction : sat_inc

  assign status = {line_state, low_power_request_n, transceiver_speed_select,
                   state_r};

  hsd_axil_regs u_regs (
    .clk(clk),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctrl_enable(ctrl_enable),
    .ctrl_start_hs(ctrl_start_hs),
    .resume_pulse(resume_pulse),
    .status(status),
    .event_set(ev_set_r)
  );

  // ----------------------------------------------------------------
  // Timing counters
  // ----------------------------------------------------------------
  // Activity counter restarts on every line level change, so it measures
  // time since the last bus activity, up to CNT_MAX cycles where it holds.
  always_ff @(posedge clk) begin
    if (srst) begin
      ls_prev_r <= LS_J;
      act_cnt_r <= '0;
    end else begin
      ls_prev_r <= line_state;
      if (line_state != ls_prev_r) begin
        act_cnt_r <= '0;
      end else begin
        act_cnt_r <= sat_inc(act_cnt_r);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      st_cnt_r <= '0;
    end else begin
      st_cnt_r <= sat_inc(st_cnt_r);
    end
  end

  // A resume request is held until suspend may legally end
  always_ff @(posedge clk) begin
    if (srst) begin
      resume_req_r <= 1'b0;
    end else if (resume_pulse && state_r == ST_SUSPEND) begin
      resume_req_r <= 1'b1;
    end else if (state_r != ST_SUSPEND) begin
      resume_req_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset, suspend and handshake sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: begin
        if (ctrl_enable) begin
          state_nxt = ctrl_start_hs ? ST_HS : ST_FS;
        end
      end
      ST_FS: begin
        if (line_state == LS_SE0 && act_cnt_r >= CNT_W'(SE0_FILT_CYC)) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_HS: begin
        if (line_state == LS_SE0 && act_cnt_r >= CNT_W'(REVERT_CYC)) begin
          state_nxt = ST_REVERT;
        end
      end
      ST_REVERT: begin
        if (st_cnt_r >= CNT_W'(SAMPLE_CYC)) begin
          if (line_state == LS_J) begin
            state_nxt = ST_SUSPEND;
          end else if (line_state == LS_SE0) begin
            state_nxt = ST_SETUP;
          end else begin
            state_nxt = ST_FS;
          end
        end
      end
      ST_SUSPEND: begin
        if (line_state == LS_SE0) begin
          state_nxt = ST_WAKE;
        end else if (resume_req_r &&
                     act_cnt_r >= CNT_W'(RESUME_MIN_CYC)) begin
          state_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (st_cnt_r >= CNT_W'(RESUME_K_CYC)) begin
          state_nxt = ST_FS;
        end
      end
      ST_WAKE: begin
        // Wake wait is sized so wake plus chirp fits the 6 ms budget
        if (st_cnt_r >= CNT_W'(WAKE_CYC)) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (st_cnt_r >= CNT_W'(SETUP_CYC)) begin
          state_nxt = ST_CHIRP;
        end
      end
      ST_CHIRP: begin
        if (st_cnt_r >= CNT_W'(CHIRP_CYC)) begin
          state_nxt = ST_LISTEN;
        end
      end
      ST_LISTEN: begin
        // Own chirp also shows K, so host chirps are judged afterwards
        if (line_state == LS_K && act_cnt_r >= CNT_W'(CHIRP_FILT_CYC)) begin
          state_nxt = ST_HS;
        end else if (st_cnt_r >= CNT_W'(LISTEN_CYC)) begin
          state_nxt = ST_AWAIT_END;
        end
      end
      ST_AWAIT_END: begin
        if (line_state != LS_SE0) begin
          state_nxt = ST_FS;
        end
      end
    endcase
    if (!ctrl_enable) begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transceiver controls, registered from the next state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      transceiver_speed_select <= SPEED_FS;
      termination_speed_select <= SPEED_FS;
      operating_mode_select <= OPSEL_NORMAL;
      low_power_request_n <= 1'b1;
      tx_data <= CHIRP_DATA;
      tx_valid <= 1'b0;
    end else begin
      transceiver_speed_select <= (state_nxt == ST_HS ||
                                   state_nxt == ST_SETUP ||
                                   state_nxt == ST_CHIRP ||
                                   state_nxt == ST_LISTEN)
                                  ? SPEED_HS : SPEED_FS;
      termination_speed_select <= (state_nxt == ST_HS)
                                  ? SPEED_HS : SPEED_FS;
      operating_mode_select <= (state_nxt == ST_SETUP ||
                                state_nxt == ST_CHIRP ||
                                state_nxt == ST_RESUME)
                               ? OPSEL_RAW : OPSEL_NORMAL;
      low_power_request_n <= (state_nxt != ST_SUSPEND);
      tx_data <= CHIRP_DATA;
      tx_valid <= (state_nxt == ST_CHIRP || state_nxt == ST_RESUME);
    end
  end

  // Event pulses for the sticky event register
  always_ff @(posedge clk) begin
    if (srst) begin
      ev_set_r <= '0;
    end else begin
      ev_set_r <= '0;
      ev_set_r[EV_RESET] <= (state_nxt == ST_SETUP && state_r != ST_SETUP);
      ev_set_r[EV_SUSPEND] <= (state_nxt == ST_SUSPEND &&
                               state_r != ST_SUSPEND);
      ev_set_r[EV_CHIRP_TO] <= (state_nxt == ST_AWAIT_END &&
                                state_r == ST_LISTEN);
      ev_set_r[EV_HOST_CHIRP] <= (state_nxt == ST_HS &&
                                  state_r == ST_LISTEN);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_HS_REVERT: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_HS && state_nxt == ST_REVERT) |->
      act_cnt_r >= CNT_W'(REVERT_CYC) ##1
      (transceiver_speed_select == SPEED_FS &&
       termination_speed_select == SPEED_FS))
    else $error("FS reversion not timed from idle");

  AST_SAMPLE_WINDOW: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_REVERT && state_nxt != ST_REVERT && ctrl_enable) |->
      (st_cnt_r >= CNT_W'(SAMPLE_CYC) &&
       st_cnt_r <= CNT_W'(SAMPLE_MAX_CYC)))
    else $error("Line sample outside window");

  AST_SE0_RESET: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_REVERT && state_nxt != ST_REVERT &&
     line_state == LS_SE0 && ctrl_enable) |=> state_r == ST_SETUP)
    else $error("SE0 sample did not start handshake");

  AST_SUSPEND_LP: assert property (@(posedge clk) disable iff (srst)
    $rose(state_r == ST_SUSPEND) |->
      !low_power_request_n throughout (state_r == ST_SUSPEND) [*2])
    else $error("Suspend without low power request");

  AST_RESUME_GAP: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_SUSPEND && state_nxt == ST_RESUME) |->
      act_cnt_r >= CNT_W'(RESUME_MIN_CYC))
    else $error("Resume too early");

  AST_FS_SE0: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_FS && state_nxt == ST_SETUP) |->
      (line_state == LS_SE0 && act_cnt_r >= CNT_W'(SE0_FILT_CYC)))
    else $error("FS reset taken on short SE0");

  AST_CHIRP_MODE: assert property (@(posedge clk) disable iff (srst)
    $rose(tx_valid) && state_r == ST_CHIRP |->
      ($past(operating_mode_select, 5) == OPSEL_RAW &&
       transceiver_speed_select == SPEED_HS && tx_data == CHIRP_DATA))
    else $error("Chirp drive setup wrong");

  AST_CHIRP_LEN: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_CHIRP && state_nxt == ST_LISTEN) |->
      (st_cnt_r >= CNT_W'(CHIRP_CYC) && $past(tx_valid)))
    else $error("Chirp K too short");

  AST_LISTEN_TO: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_LISTEN && state_nxt == ST_AWAIT_END) |->
      st_cnt_r >= CNT_W'(LISTEN_CYC) ##1
      (transceiver_speed_select == SPEED_FS && !tx_valid))
    else $error("No FS return after silent host");
endmodule : hsd_ctrl
`default_nettype wire

// >>> hsd_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsd_phy_model (
  input wire logic [1:0] host_mode,
  input wire logic transceiver_speed_select,
  input wire logic termination_speed_select,
  input wire logic [1:0] operating_mode_select,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [1:0] line_state
);
  import hsd_pkg::*;
  // ----------------------------------------------------------------
  // Bus level: host 0 drives SE0, 1 releases, 2 chirps K
  // ----------------------------------------------------------------
  // Combinational, so line level is valid on every edge
  always_comb begin
    if (host_mode == 2'h2)
      line_state = LS_K;
    else if (tx_valid && operating_mode_select == OPSEL_RAW)
      line_state = (tx_data == CHIRP_DATA) ? LS_K : LS_J;
    else if (host_mode == 2'h0)
      line_state = LS_SE0;
    else if (termination_speed_select == SPEED_FS)
      line_state = LS_J;
    else
      line_state = LS_SE0;
  end
endmodule : hsd_phy_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hsd_pkg::*;
  localparam int RV = 200, SM = 20, SX = 80, CH = 150, LI = 120;
  localparam int RM = 300, RK = 50, WK = 100;
  logic clk = 0, srst = 1;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, transceiver_speed_select, termination_speed_select;
  logic low_power_request_n, tx_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, line_state, operating_mode_select;
  logic [1:0] hm = 2'h1;
  logic [7:0] tx_data;
  logic [3:0] pv;
  int error_cnt = 0, n_compared = 0, cyc = 0, n, t;
  assign pv = {termination_speed_select, low_power_request_n, tx_valid,
    transceiver_speed_select};
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  hsd_ctrl #(.REVERT_CYC(RV), .SAMPLE_CYC(SM), .SAMPLE_MAX_CYC(SX),
    .CHIRP_CYC(CH), .LISTEN_CYC(LI), .RESUME_MIN_CYC(RM),
    .RESUME_K_CYC(RK), .WAKE_CYC(WK)) u_dut (.clk, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_state,
    .transceiver_speed_select, .termination_speed_select,
    .operating_mode_select, .low_power_request_n, .tx_data, .tx_valid);
  hsd_phy_model u_phy (.host_mode(hm), .transceiver_speed_select,
    .termination_speed_select, .operating_mode_select, .tx_data,
    .tx_valid, .line_state);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] rng(input int v, lo, hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction : rng
  // Counts edges until probe s shows v; the watchdog ends a hang
  task automatic wt(input int s, input logic v);
    n = 0;
    while (pv[s] !== v) begin
      @(posedge clk);
      n++;
    end
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] er);
    bit aw, w;
    @(posedge clk);
    {aw, w} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(REG_CTRL, 0, RESP_OKAY);
    rd(REG_STATUS, 32'h70, RESP_OKAY);
    rd(4'hC, 0, RESP_SLVERR);
    wr(4'hC, 32'hFF, RESP_SLVERR);
    rd(REG_CTRL, 0, RESP_OKAY);
    // Reset from HS with an FS-only host: no host chirps
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    // HS selection lands one edge after the write response
    wt(0, SPEED_HS);
    hm <= 2'h0;
    wt(0, SPEED_FS);
    chk("revert", rng(n, RV - 4, RV + 6), 1);
    wt(1, 1'b1);
    chk("sample", rng(n, SM, SX + 8), 1);
    chk("operating_mode_select", 32'(operating_mode_select), 32'(OPSEL_RAW));
    chk("xcvr", 32'(transceiver_speed_select), 32'(SPEED_HS));
    chk("term", 32'(termination_speed_select), 32'(SPEED_FS));
    chk("txdata", 32'(tx_data), 32'(CHIRP_DATA));
    wt(1, 1'b0);
    chk("chirp", rng(n, CH, CH + 2), 1);
    wt(0, SPEED_FS);
    chk("listen", rng(n, LI - 3, LI + 3), 1);
    chk("opm", 32'(operating_mode_select), 32'(OPSEL_NORMAL));
    rd(REG_EVENT, 32'h5, RESP_OKAY);
    wr(REG_EVENT, 32'hF, RESP_OKAY);
    rd(REG_EVENT, 0, RESP_OKAY);
    hm <= 2'h1;
    rd(REG_STATUS, 32'h71, RESP_OKAY);
    // FS reset, HS host answers the chirp
    hm <= 2'h0;
    wt(1, 1'b1);
    chk("fs_se0", rng(n, SE0_FILT_CYC, SE0_FILT_CYC + 10), 1);
    wt(1, 1'b0);
    hm <= 2'h2;
    wt(3, SPEED_HS);
    chk("hostk", rng(n, CHIRP_FILT_CYC, CHIRP_FILT_CYC + 4), 1);
    rd(REG_EVENT, 32'h9, RESP_OKAY);
    // HS idle becomes suspend, then resume
    hm <= 2'h1;
    wt(0, SPEED_FS);
    chk("revert2", rng(n, RV - 2, RV + 3), 1);
    t = cyc;
    @(posedge clk);
    chk("pullup", 32'(line_state), 32'(LS_J));
    wt(2, 1'b0);
    chk("suspend", rng(n, SM - 2, SX), 1);
    rd(REG_EVENT, 32'hB, RESP_OKAY);
    wr(REG_CTRL, 32'h7, RESP_OKAY);
    wt(1, 1'b1);
    chk("resume", rng(cyc - t, RM, RM + 20), 1);
    chk("rsm_opm", 32'(operating_mode_select), 32'(OPSEL_RAW));
    wt(1, 1'b0);
    chk("resumek", rng(n, RK - 1, RK + 2), 1);
    // Suspend again, host SE0 wakes it and the handshake follows the wake wait
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    wt(2, 1'b0);
    chk("susp2", rng(n, RV, RV + SX + 10), 1);
    hm <= 2'h0;
    wt(2, 1'b1);
    chk("wake", rng(n, 0, 3), 1);
    wt(1, 1'b1);
    chk("wakechirp", rng(n, WK, WK + 12), 1);
    wt(1, 1'b0);
    chk("chirp2", rng(n, CH, CH + 2), 1);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
